// ==== pkg/adc_ctrl_defines.vh ====
// constants of the converter control block: register indices,
// field positions, reset values and conversion lengths.
// assumes inclusion by bare name from the rtl and verification files.
`ifndef ADC_CTRL_DEFINES_VH
`define ADC_CTRL_DEFINES_VH

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define CSRA_IDX        6'h06
`define CHSEL_IDX       6'h07
`define RESULT_IDX      6'h08
`define IRQ_STAT_IDX    6'h09
`define IRQ_MASK_IDX    6'h0a
`define MODE_IDX        6'h0b

// ----------------------------------------------------------------
// control/status register a fields
// ----------------------------------------------------------------
`define CSRA_EN_BIT     7
`define CSRA_START_BIT  6
`define CSRA_ATE_BIT    5
`define CSRA_FLAG_BIT   4
`define CSRA_IE_BIT     3
`define CSRA_PS_MSB     2
`define CSRA_PS_LSB     0
`define CSRA_RESET      8'h00

// ----------------------------------------------------------------
// interrupt status / mask fields, mode register
// ----------------------------------------------------------------
`define IRQ_DONE_BIT    0
`define IRQ_ABORT_BIT   1
`define IRQ_RESET       2'h0
`define MODE_FREE_BIT   0
`define CHSEL_RESET     6'h00

// ----------------------------------------------------------------
// channel codes and conversion lengths in converter clock cycles
// ----------------------------------------------------------------
`define TEMP_SENSOR_CODE  6'h3f
`define LAST_SINGLE_CODE  6'h0a
`define FIRST_CONV_CYCLES 5'd25
`define NORM_CONV_CYCLES  5'd13

// ----------------------------------------------------------------
// ahb transfer type bit that marks nonseq/seq
// ----------------------------------------------------------------
`define HTRANS_ACTIVE_BIT 1

`endif

// ==== rtl/conv_clock_prescaler.v ====
// converter clock prescaler: one-cycle tick every 2^n hclk cycles.
// assumes clear is synchronous to hclk; n = 0 divides by 2.
`timescale 1ns/1ns

module conv_clock_prescaler (
    input  wire       hclk,
    input  wire       hresetn,
    input  wire       clear,
    input  wire [2:0] prescale,
    output wire       tick
);

    // ------------------------------------------------------------
    // division counter
    // ------------------------------------------------------------
    reg  [6:0] cnt_r;     // hclk cycles into current converter cycle
    reg        tick_r;    // converter clock tick
    reg  [6:0] last_cnt;  // terminal count for this setting

    // divide ratio 2,2,4,8,...,128
    always @* begin
        case (prescale)
            3'h0:    last_cnt = 7'h01;
            3'h1:    last_cnt = 7'h01;
            3'h2:    last_cnt = 7'h03;
            3'h3:    last_cnt = 7'h07;
            3'h4:    last_cnt = 7'h0f;
            3'h5:    last_cnt = 7'h1f;
            3'h6:    last_cnt = 7'h3f;
            default: last_cnt = 7'h7f;
        endcase
    end

    // clear restarts the phase so a trigger has a fixed delay
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r  <= 7'h00;
            tick_r <= 1'b0;
        end else if (clear) begin
            cnt_r  <= 7'h00;
            tick_r <= 1'b0;
        end else if (cnt_r >= last_cnt) begin
            cnt_r  <= 7'h00;
            tick_r <= 1'b1;
        end else begin
            cnt_r  <= cnt_r + 7'h01;
            tick_r <= 1'b0;
        end
    end

    assign tick = tick_r;

endmodule

// ==== rtl/adc_conversion_control.v ====
// control and status logic of a 10-bit successive-approximation
// converter, reached over an ahb-lite slave.
// assumes one clock hclk, async active-low reset, trigger_in and
// result_in synchronous to hclk.
// assumes one ahb-lite master; hsize is not checked, so
// software must issue whole-word transfers only.
// assumes result_in steady on the completing tick.
`timescale 1ns/1ns
`include "adc_ctrl_defines.vh"

module adc_conversion_control (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    input  wire        trigger_in,
    input  wire [9:0]  result_in,
    output wire        converter_on,
    output wire        conv_active,
    output wire [5:0]  analog_channel,
    output wire        temp_sensor_route,
    output wire        gain_bypass,
    output wire        irq
);

    // ------------------------------------------------------------
    // states and declarations
    // ------------------------------------------------------------
    // two states only: the run length is timed by a
    // counter of converter ticks, not by extra states
    localparam ST_IDLE = 2'b01;   // converter idle
    localparam ST_BUSY = 2'b10;   // conversion running

    reg  [1:0]  state_r;          // one-hot state
    reg  [1:0]  state_nxt;
    reg         enable_r;         // converter_enable
    reg         start_r;          // conversion_start
    reg         ate_r;            // auto_trigger_enable
    reg         flag_r;           // conversion_done_flag
    reg         ie_r;             // conversion_done_irq_enable
    reg  [2:0]  ps_r;             // converter_clock_prescale
    reg         free_r;           // free-running mode
    reg  [5:0]  chsel_r;          // input_channel_select as written
    reg  [5:0]  active_ch_r;      // channel of running conversion
    reg         temp_r;           // temperature sensor routed
    reg         bypass_r;         // gain stage bypassed
    reg         first_r;          // next conversion is the long one
    reg  [4:0]  cnt_r;            // converter cycles into conversion
    reg  [4:0]  len_r;            // length of running conversion
    reg  [9:0]  result_r;         // last stored result
    reg  [1:0]  stat_r;           // sticky interrupt status
    reg  [1:0]  mask_r;           // interrupt mask
    reg         irq_r;            // interrupt line
    reg         trig_d_r;         // trigger delayed for edge detect
    reg         wr_pend_r;        // write data phase pending
    reg  [5:0]  wr_idx_r;         // index of pending write
    reg  [31:0] hrdata_r;         // read data of data phase
    reg  [31:0] rd_mux;           // read data selected by address
    wire        tick;             // converter clock tick
    wire        addr_ok;          // address inside the block window
    wire        take;             // transfer accepted this edge
    wire        wr_csr;           // write to control/status a
    wire        enabling;         // enable written 0 -> 1
    wire        disabling;        // enable written 1 -> 0
    wire        idle;             // no conversion in progress
    wire        sw_start;         // software start request
    wire        hw_trig;          // trigger start request
    wire        start_go;         // a conversion begins this edge
    wire        done;             // running conversion completes
    wire        abort;            // running conversion aborted
    wire        restart;          // free-running follow-on
    wire        flag_clr;         // software clears done flag
    wire [1:0]  stat_clr;         // software clears status bits
    wire [1:0]  stat_set;         // events this cycle

    // ------------------------------------------------------------
    // ahb-lite address phase capture
    // ------------------------------------------------------------
    // only word index bits decode; upper bits must be zero so the
    // block does not alias through the whole slot
    assign addr_ok = (haddr[31:8] == 24'h000000);
    assign take    = hsel & hready & htrans[`HTRANS_ACTIVE_BIT];

    // taken only while the bus is ready, so a stalled
    // transfer of another slave never lands here twice

    // read mux; unmapped addresses read as zero
    // channel word shows both the written selection and
    // the channel in use, so software sees when a new
    // selection has taken effect
    always @* begin
        rd_mux = 32'h00000000;
        if (addr_ok) begin
            case (haddr[7:2])
                `CSRA_IDX:
                    rd_mux[7:0] = {enable_r, start_r, ate_r, flag_r,
                                   ie_r, ps_r};
                `CHSEL_IDX: begin
                    rd_mux[5:0]  = chsel_r;
                    rd_mux[13:8] = active_ch_r;
                end
                `RESULT_IDX:   rd_mux[9:0] = result_r;
                `IRQ_STAT_IDX: rd_mux[1:0] = stat_r;
                `IRQ_MASK_IDX: rd_mux[1:0] = mask_r;
                `MODE_IDX:     rd_mux[0]   = free_r;
                default:       rd_mux      = 32'h00000000;
            endcase
        end
    end

    // zero wait state: read data sampled at the address edge and
    // held through the data phase; response always okay
    // trade-off: a read in the data phase of a write to
    // the same register returns the old value; software
    // reads twice or leaves one idle cycle between
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_idx_r  <= 6'h00;
            hrdata_r  <= 32'h00000000;
        end else begin
            wr_pend_r <= take & hwrite & addr_ok;
            if (take) begin
                wr_idx_r <= haddr[7:2];
            end
            if (take & ~hwrite) begin
                hrdata_r <= rd_mux;
            end
        end
    end

    assign hrdata    = hrdata_r;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ------------------------------------------------------------
    // write decode and start conditions
    // ------------------------------------------------------------
    assign wr_csr    = wr_pend_r & (wr_idx_r == `CSRA_IDX);
    assign enabling  = wr_csr & hwdata[`CSRA_EN_BIT] & ~enable_r;
    assign disabling = wr_csr & ~hwdata[`CSRA_EN_BIT] & enable_r;
    assign idle      = state_r[0];

    // a one starts only if the converter is or becomes enabled;
    // a zero is never looked at, so it cancels nothing
    // a start while busy is dropped, not queued, so
    // one write never yields two conversions
    assign sw_start  = wr_csr
                       & hwdata[`CSRA_START_BIT]
                       & hwdata[`CSRA_EN_BIT]
                       & idle;
    // edges during a conversion are dropped, not queued
    assign hw_trig   = ate_r & ~free_r & enable_r & idle & ~disabling
                       & trigger_in & ~trig_d_r;
    assign start_go  = sw_start | hw_trig;

    // last tick of the running length; a disable in the
    // same cycle wins, so no result lands after abort
    assign done      = state_r[1] & tick
                       & (cnt_r == len_r - 5'd1)
                       & ~disabling;
    assign abort     = state_r[1] & disabling;
    // free-running needs only the first start write;
    // later runs follow on from each completion
    assign restart   = done & ate_r & free_r;

    assign flag_clr  = wr_csr & hwdata[`CSRA_FLAG_BIT];
    assign stat_clr  = (wr_pend_r & (wr_idx_r == `IRQ_STAT_IDX)) ? hwdata[1:0] : 2'h0;
    // bit 0 marks completion, bit 1 an abort; both stay
    // set until software writes a one to them
    assign stat_set  = {abort, done};

    // ------------------------------------------------------------
    // converter clock prescaler
    // ------------------------------------------------------------
    // held cleared while off; every start resets its phase
    // so trigger to first tick is a fixed delay;
    // limitation: a software start loses the phase too
    conv_clock_prescaler u_presc (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .clear    (start_go | ~enable_r),
        .prescale (ps_r),
        .tick     (tick)
    );

    // ------------------------------------------------------------
    // conversion state machine
    // ------------------------------------------------------------
    // idle until a start, busy until the last tick
    // unless free-running carries on; abort goes idle
    // an illegal code falls back to idle
    always @* begin
        case (state_r)
            ST_IDLE:  state_nxt = start_go ? ST_BUSY : ST_IDLE;
            ST_BUSY: begin
                if (abort)
                    state_nxt = ST_IDLE;
                else if (done & ~restart)
                    state_nxt = ST_IDLE;
                else
                    state_nxt = ST_BUSY;
            end
            default:  state_nxt = ST_IDLE;
        endcase
    end

    // counters, channel latch and the start bit
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r     <= ST_IDLE;
            cnt_r       <= 5'd0;
            len_r       <= `NORM_CONV_CYCLES;
            first_r     <= 1'b0;
            start_r     <= 1'b0;
            active_ch_r <= `CHSEL_RESET;
            temp_r      <= 1'b0;
            bypass_r    <= 1'b1;
            result_r    <= 10'h000;
        end else begin
            state_r <= state_nxt;
            // long first conversion armed by each enable; a
            // start in the enabling write takes the long length
            // itself, so the flag must not stay armed after it
            if (start_go | disabling)
                first_r <= 1'b0;
            else if (enabling)
                first_r <= 1'b1;
            if (start_go | restart) begin
                cnt_r <= 5'd0;
                // enabling in the same write also counts as first
                len_r <= (first_r | enabling) & start_go ?
                         `FIRST_CONV_CYCLES : `NORM_CONV_CYCLES;
                // new selection only at a conversion boundary
                active_ch_r <= chsel_r;
                temp_r      <= (chsel_r == `TEMP_SENSOR_CODE);
                bypass_r    <= (chsel_r <= `LAST_SINGLE_CODE)
                               | (chsel_r == `TEMP_SENSOR_CODE);
            end else if (state_r[1] & tick) begin
                cnt_r <= cnt_r + 5'd1;
            end
            // start bit mirrors the running conversion
            if (start_go)
                start_r <= 1'b1;
            else if (abort | disabling)
                start_r <= 1'b0;
            else if (done & ~restart)
                start_r <= 1'b0;
            // taken on the completing edge only; an aborted
            // run leaves the previous result in place
            if (done)
                result_r <= result_in;
        end
    end

    // outputs to the analog core, all from flip-flops
    assign conv_active       = state_r[1];
    assign analog_channel    = active_ch_r;
    assign temp_sensor_route = temp_r;
    assign gain_bypass       = bypass_r;

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    // sticky bits: a set in the clearing cycle wins over the clear
    // so a completion meeting a clear is never lost; the
    // cost: the flag may reappear right after clearing
    // trigger delay runs every cycle, so the first edge
    // after enable is judged against the real level
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_r <= 1'b0;
            ate_r    <= 1'b0;
            flag_r   <= 1'b0;
            ie_r     <= 1'b0;
            ps_r     <= 3'h0;
            free_r   <= 1'b0;
            chsel_r  <= `CHSEL_RESET;
            stat_r   <= `IRQ_RESET;
            mask_r   <= `IRQ_RESET;
            trig_d_r <= 1'b0;
        end else begin
            trig_d_r <= trigger_in;
            if (wr_csr) begin
                enable_r <= hwdata[`CSRA_EN_BIT];
                ate_r    <= hwdata[`CSRA_ATE_BIT];
                ie_r     <= hwdata[`CSRA_IE_BIT];
                ps_r     <= hwdata[`CSRA_PS_MSB:`CSRA_PS_LSB];
            end
            flag_r <= done | (flag_r & ~flag_clr);
            stat_r <= stat_set | (stat_r & ~stat_clr);
            if (wr_pend_r & (wr_idx_r == `IRQ_MASK_IDX))
                mask_r <= hwdata[1:0];
            if (wr_pend_r & (wr_idx_r == `MODE_IDX))
                free_r <= hwdata[`MODE_FREE_BIT];
            if (wr_pend_r & (wr_idx_r == `CHSEL_IDX))
                chsel_r <= hwdata[5:0];
        end
    end

    assign converter_on = enable_r;

    // ------------------------------------------------------------
    // interrupt line
    // ------------------------------------------------------------
    // registered, so it follows the flags one cycle late
    // sources: done flag with its enable, and any
    // status bit left open by the mask
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            irq_r <= 1'b0;
        else
            irq_r <= (flag_r & ie_r) | (|(stat_r & mask_r));
    end

    assign irq = irq_r;

endmodule

// ==== verification/adc_conversion_control_props.sv ====
// port checker for the converter control block.
// assumes a bind onto adc_conversion_control, one hclk domain.
`timescale 1ns/1ns
`include "adc_ctrl_defines.vh"

module adc_ctrl_checker (
    input wire       hclk,
    input wire       hresetn,
    input wire       hreadyout,
    input wire       hresp,
    input wire       converter_on,
    input wire       conv_active,
    input wire [5:0] analog_channel,
    input wire       temp_sensor_route,
    input wire       gain_bypass
);
    // ------------------------------------------------------------
    // run length helper
    // ------------------------------------------------------------
    reg [11:0] run_len_r; // cycles the current run has lasted
    reg        first_r;   // next completion ends the first run
    // free-run restarts never drop conv_active, so stop them by disabling
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_len_r <= 12'h000;
            first_r   <= 1'b1;
        end else begin
            run_len_r <= conv_active ? run_len_r + 12'h001 : 12'h000;
            if (!converter_on)
                first_r <= 1'b1; // re-armed while switched off
            else if ($fell(conv_active))
                first_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    conv_needs_on_a: assert property (conv_active |-> converter_on)
        else $error("conversion runs while converter off");
    abort_stops_a: assert property ($past(conv_active) && $fell(converter_on) |-> $fell(conv_active))
        else $error("disable did not abort conversion");
    temp_route_a: assert property (temp_sensor_route == (analog_channel == `TEMP_SENSOR_CODE))
        else $error("temperature route wrong for channel");
    gain_bypass_a: assert property (gain_bypass == (analog_channel <= `LAST_SINGLE_CODE ||
                                    analog_channel == `TEMP_SENSOR_CODE))
        else $error("gain bypass wrong for channel");
    chan_hold_a: assert property ($rose(conv_active) |=> $stable(analog_channel) [*8])
        else $error("channel changed during conversion");
    first_len_a: assert property ($fell(conv_active) && converter_on && first_r |-> run_len_r >= 12'd48)
        else $error("first conversion too short");
    norm_len_a: assert property ($fell(conv_active) && converter_on && !first_r |-> run_len_r >= 12'd24)
        else $error("normal conversion too short");
endmodule

bind adc_conversion_control adc_ctrl_checker i_chk (
    .hclk              (hclk),
    .hresetn           (hresetn),
    .hreadyout         (hreadyout),
    .hresp             (hresp),
    .converter_on      (converter_on),
    .conv_active       (conv_active),
    .analog_channel    (analog_channel),
    .temp_sensor_route (temp_sensor_route),
    .gain_bypass       (gain_bypass)
);

// ==== verification/adc_conversion_control_bench.sv ====
// self-checking bench for the converter control block.
// assumes zero-wait ahb-lite slave, prescale 0 (tick every 2 hclk).
`timescale 1ns/1ns
`include "adc_ctrl_defines.vh"

module adc_conversion_control_bench;
    reg         hclk, hresetn, hsel, hwrite, trigger_in;
    reg  [31:0] haddr, hwdata, rd;
    reg  [1:0]  htrans;
    reg  [9:0]  result_in;
    reg  [5:0]  ch;
    wire [31:0] hrdata;
    wire [5:0]  analog_channel;
    wire        hreadyout, hresp, converter_on, conv_active, temp_sensor_route, gain_bypass, irq;
    integer     fails, n_compared, seed, n, i;
    localparam [31:0] a_csra = `CSRA_IDX * 4;     // control/status a
    localparam [31:0] a_chsel = `CHSEL_IDX * 4;   // channel select
    localparam [31:0] a_result = `RESULT_IDX * 4; // conversion result
    localparam [31:0] a_stat = `IRQ_STAT_IDX * 4; // irq status
    localparam [31:0] a_mask = `IRQ_MASK_IDX * 4; // irq mask
    localparam [31:0] a_mode = `MODE_IDX * 4;     // free-run mode

    adc_conversion_control i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .trigger_in(trigger_in),
        .result_in(result_in), .converter_on(converter_on), .conv_active(conv_active),
        .analog_channel(analog_channel), .temp_sensor_route(temp_sensor_route),
        .gain_bypass(gain_bypass), .irq(irq));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    function exp_bypass(input [5:0] c); // single-ended codes skip gain
        exp_bypass = (c <= 6'h0a) || (c == 6'h3f);
    endfunction
    task check(input [31:0] seen, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task test_done;
        begin
            $display("compared %0d mismatched %0d", n_compared, fails);
            if (fails == 0 && n_compared > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    task give_up; // a bounded wait ran out
        begin
            fails = fails + 1;
            $display("[ERR] %0t wait ran out", $time);
            test_done;
        end
    endtask
    task step(input integer c); // let edge updates land before sampling
        begin
            repeat (c) @(posedge hclk);
            #1;
        end
    endtask
    // single ahb transfer; hready waits are bounded
    task bus(input w, input [31:0] a, input [31:0] d);
        integer k;
        begin
            k = 0;
            @(posedge hclk);
            hsel <= 1'b1;
            haddr <= a;
            hwrite <= w;
            htrans <= 2'b10;
            @(posedge hclk);
            while (hreadyout !== 1'b1 && k < 20) begin
                @(posedge hclk);
                k = k + 1;
            end
            htrans <= 2'b00;
            hsel <= 1'b0;
            hwdata <= d;
            @(posedge hclk);
            while (hreadyout !== 1'b1 && k < 20) begin
                @(posedge hclk);
                k = k + 1;
            end
            rd = hrdata;
            if (k >= 20)
                give_up;
            #1;
        end
    endtask
    task wait_done; // cycles until conv_active drops, kept in n
        begin
            n = 0;
            while (conv_active !== 1'b0 && n < 4000) begin
                step(1);
                n = n + 1;
            end
            if (n >= 4000)
                give_up;
        end
    endtask
    task wait_flag; // poll the done flag over the bus
        integer k;
        begin
            k = 0;
            rd = 32'h0;
            while (rd[4] !== 1'b1 && k < 100) begin
                bus(1'b0, a_csra, 32'h0);
                k = k + 1;
            end
            if (k >= 100)
                give_up;
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'h316615da;
        fails = 0;
        n_compared = 0;
        {hresetn, hsel, hwrite, trigger_in, htrans, haddr, hwdata} = 0;
        result_in = $random(seed);
        step(8);
        hresetn <= 1'b1;
        check(gain_bypass, 1'b1);
        bus(1'b0, a_csra, 0); check(rd, 32'h0);
        bus(1'b0, 32'h3c, 0); check(rd, 32'h0);
        bus(1'b1, a_csra, 32'h40); // start while off is ignored
        step(2); check(conv_active, 1'b0);
        $display("reset test done");
        // first conversion after enable, irq enabled
        bus(1'b1, a_csra, 32'hc8);
        bus(1'b0, a_csra, 0); check(rd[6], 1'b1);
        wait_done; check(n >= 40, 1'b1);
        bus(1'b0, a_result, 0); check(rd, {22'h0, result_in});
        bus(1'b0, a_csra, 0); check(rd, 32'h98);
        check(irq, 1'b1);
        bus(1'b1, a_csra, 32'h98); // flag is write-one-to-clear
        step(1); check(irq, 1'b0);
        $display("first conversion test done");
        for (i = 0; i < 5; i = i + 1) begin
            ch = (i == 0) ? 6'h3f : $random(seed);
            result_in = $random(seed);
            bus(1'b1, a_chsel, ch);
            bus(1'b1, a_csra, 32'hc0);
            bus(1'b1, a_chsel, ~ch); // moved mid-run
            bus(1'b1, a_csra, 32'h80); // zero to start
            bus(1'b0, a_csra, 0); check(rd[6], 1'b1);
            check(analog_channel, ch);
            check(temp_sensor_route, ch == 6'h3f);
            check(gain_bypass, exp_bypass(ch));
            wait_done; check(n >= 10 && n <= 30, 1'b1);
            bus(1'b0, a_result, 0); check(rd, {22'h0, result_in});
        end
        $display("single conversion test done");
        bus(1'b1, a_mask, 32'h2);
        bus(1'b1, a_csra, 32'hc0);
        bus(1'b1, a_csra, 32'h0); // disable mid-run
        check(conv_active, 1'b0);
        check(converter_on, 1'b0);
        // done bit still set from the earlier runs
        bus(1'b0, a_stat, 0); check(rd[1:0], 2'b11);
        check(irq, 1'b1);
        bus(1'b1, a_mask, 32'h0);
        step(1); check(irq, 1'b0);
        bus(1'b1, a_mask, 32'h2);
        bus(1'b1, a_stat, 32'h2);
        step(1); check(irq, 1'b0);
        $display("abort test done");
        bus(1'b1, a_mode, 32'h1);
        bus(1'b1, a_csra, 32'hf0); // free running, stale flag cleared
        wait_flag; check(rd[6], 1'b1);
        check(conv_active, 1'b1);
        bus(1'b1, a_csra, 32'hb0); // clear flag, no start write
        wait_flag; check(rd[6], 1'b1);
        bus(1'b1, a_csra, 32'h0);
        $display("free running test done");
        bus(1'b1, a_mode, 32'h0);
        bus(1'b1, a_csra, 32'ha0); // enable with auto trigger
        step(3); check(conv_active, 1'b0);
        @(posedge hclk) trigger_in <= 1'b1;
        @(posedge hclk) trigger_in <= 1'b0;
        step(3); check(conv_active, 1'b1);
        @(posedge hclk) trigger_in <= 1'b1; // edge while busy
        @(posedge hclk) trigger_in <= 1'b0;
        wait_done; check(n >= 35, 1'b1);
        step(6); check(conv_active, 1'b0);
        $display("trigger test done");
        test_done;
    end
endmodule
